// File: rtl/aso_pkg.sv
/*
  Shared constants and state types for the serial output port of a
  sigma-delta converter and for the host end that reads it.
  Assumes both ends compile against this package before any module.
*/
package aso_pkg;

  // Conversion word
  localparam int ASO_WORD_W = 20;
  localparam int ASO_BIT_CNT_W = 5;
  localparam logic [ASO_BIT_CNT_W-1:0] ASO_LAST_BIT = 5'h13;
  localparam logic [ASO_BIT_CNT_W-1:0] ASO_BIT_CNT_RST = 5'h00;
  localparam logic [ASO_WORD_W-1:0] ASO_WORD_RST = 20'h00000;

  // Internal timing of the device: 16 periods of 64 master clocks
  localparam int ASO_PERIODS = 16;
  localparam int ASO_PERIOD_CLKS = 64;
  localparam int ASO_TIME_W = 10;
  localparam logic [ASO_TIME_W-1:0] ASO_TIME_RST = 10'h000;
  localparam int ASO_PHASE_POS = 6;
  localparam logic [5:0] ASO_PERIOD_LAST = 6'h3F;

  // Self-clocked bit cell: four master clocks per bit
  localparam logic [1:0] ASO_PHASE_RST = 2'h0;
  localparam logic [1:0] ASO_PHASE_RISE = 2'h1;
  localparam logic [1:0] ASO_PHASE_END = 2'h3;

  // Ready gap before a late word loads, in master clocks
  localparam logic [2:0] ASO_GAP_CLKS = 3'h4;
  localparam logic [2:0] ASO_GAP_RST = 3'h0;

  // Host serial clock half period in host-clocked mode
  localparam int ASO_CORE_CLK_PS = 5000;
  localparam int ASO_HOST_HALF_NS = 80;
  localparam int ASO_HOST_HALF_CLKS = (ASO_HOST_HALF_NS * 1000) / ASO_CORE_CLK_PS;
  localparam logic [4:0] ASO_HALF_LOAD = 5'(ASO_HOST_HALF_CLKS - 1);
  localparam logic [4:0] ASO_HALF_RST = 5'h00;
  localparam logic [ASO_BIT_CNT_W-1:0] ASO_HOST_BITS = 5'h14;

  // Device transfer state
  typedef enum logic [1:0]
  {
    ASO_XS_OFF = 2'b01,
    ASO_XS_SEND = 2'b10
  } aso_xfer_t;

  // Device word-ready state
  typedef enum logic [2:0]
  {
    ASO_RS_EMPTY = 3'b001,
    ASO_RS_FULL = 3'b010,
    ASO_RS_GAP = 3'b100
  } aso_rdy_t;

  // Host state
  typedef enum logic [4:0]
  {
    ASO_HS_IDLE = 5'b00001,
    ASO_HS_COLLECT = 5'b00010,
    ASO_HS_WAIT_RDY = 5'b00100,
    ASO_HS_HIGH = 5'b01000,
    ASO_HS_LOW = 5'b10000
  } aso_host_t;

endpackage : aso_pkg

// File: rtl/aso_link_if.sv
/*
  Pins between the converter's serial port and its host.
  Assumes the bench supplies master_clock_in; open wires read high.
*/
`timescale 1ns/100ps
interface aso_link_if
(
  input wire logic master_clock_in
);
  logic chip_sel_n;
  logic mode_pin;
  logic sleep_n;
  logic serial_clk_dev_o;
  logic serial_clk_dev_oe;
  logic serial_clk_host_o;
  logic serial_clk_host_oe;
  logic serial_clk_line;
  logic serial_out_o;
  logic serial_out_oe;
  logic serial_out_line;
  logic word_ready_o;
  logic word_ready_oe;
  logic word_ready_n;

  // Wire levels from the enables, pulled high when undriven
  assign serial_clk_line = serial_clk_dev_oe ? serial_clk_dev_o :
                           (serial_clk_host_oe ? serial_clk_host_o : 1'b1);
  assign serial_out_line = serial_out_oe ? serial_out_o : 1'b1;
  assign word_ready_n = word_ready_oe ? word_ready_o : 1'b1;

  modport dev
  (
    input master_clock_in, chip_sel_n, mode_pin, sleep_n, serial_clk_line,
    output serial_clk_dev_o, serial_clk_dev_oe, serial_out_o, serial_out_oe,
    output word_ready_o, word_ready_oe
  );

  modport host
  (
    input serial_clk_line, serial_out_line, word_ready_n,
    output chip_sel_n, mode_pin, sleep_n, serial_clk_host_o, serial_clk_host_oe
  );
endinterface : aso_link_if

// File: rtl/aso_dev_port.sv
/*
  Device end: holds the last conversion word it accepted and shifts it out MSB first,
  either on its own serial clock or on the host's.
  Assumes conv_word_in/conv_stb_in come from converter logic on the
  master clock; pins from the host are synchronised here.
*/
// What this block does
// RULE1: Mode high selects self-clocked serial transfer
// RULE2: Sixteen 64-clock periods, alternating settle and compute
// RULE3: Poll chip select per compute period, send MSB-first
// RULE4: Ready high after LSB until next word
// RULE5: Chip select rise: finish bit, float clock, data
// RULE6: Resume with next bit next compute period
// RULE7: Unsent word: ready high four clocks, then load
// RULE8: Data changes on falling clock, captured rising
// RULE9: Self-clocked shifting only in compute periods
// RULE10: Mode low selects host-clocked transfer
// RULE11: Chip select fall drives MSB immediately
// RULE12: Host clock falling edge advances each bit
// RULE13: After LSB, float ready and data lines
// RULE14: Busy with chip select low: drop new word
// RULE15: Chip select rise floats data at once
// RULE16: Chip select fall resumes with same bit
// RULE17: Unsent word, chip select high: gap, load
// RULE18: Host should clock device from its system clock; the bench drives master_clock_in from a clock unrelated to core_clk_in
// RULE19: Sleep low halts all port logic
// RULE20: Host should recalibrate after leaving sleep; the host end only raises sleep_n again
// RULE21: 20-bit shift register loaded at ready instant
`timescale 1ns/100ps
module aso_dev_port
  import aso_pkg::*;
(
  aso_link_if.dev link,
  input wire logic sys_rst_in,
  input wire logic [ASO_WORD_W-1:0] conv_word_in,
  input wire logic conv_stb_in,
  output logic word_pending_out,
  output logic asleep_out
);

  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic clk_prev_ff;
  logic mode_s;
  logic awake_s;
  logic cs_n_s;
  logic clk_s;
  logic host_fall;
  logic [ASO_TIME_W-1:0] time_ff;
  logic in_compute;
  logic compute_next;
  logic period_last;
  aso_xfer_t xs_ff;
  aso_rdy_t rs_ff;
  logic [1:0] phase_ff;
  logic [2:0] gap_ff;
  logic [ASO_WORD_W-1:0] shreg_ff;
  logic [ASO_WORD_W-1:0] next_word_ff;
  logic [ASO_BIT_CNT_W-1:0] bit_cnt_ff;
  logic pend_ff;
  logic host_busy;
  logic load_now;
  logic self_start;
  logic self_bit_end;
  logic last_bit;
  logic shift_now;
  logic sclk_o_ff;
  logic sclk_oe_ff;
  logic serial_out_line_o_ff;
  logic serial_out_line_oe_ff;
  logic rdy_o_ff;
  logic rdy_oe_ff;
  logic asleep_ff;

  // Two-flop synchronisers for mode, sleep, chip select, serial clock
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pin_s1_ff <= 4'hE; // Mode reads host-clocked until synced
      pin_s2_ff <= 4'hE;
    end
    else
    begin
      pin_s1_ff <= {link.serial_clk_line, link.chip_sel_n, link.sleep_n, link.mode_pin};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Previous synchronised serial clock for edge detection
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      clk_prev_ff <= 1'b1;
    else
      clk_prev_ff <= pin_s2_ff[3];
  end

  // Decoded pin levels and host clock edge
  assign mode_s = pin_s2_ff[0];
  assign awake_s = pin_s2_ff[1];
  assign cs_n_s = pin_s2_ff[2];
  assign clk_s = pin_s2_ff[3];
  assign host_fall = clk_prev_ff & ~clk_s; // RULE12

  // Sampling interval timer; odd periods are compute periods
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      time_ff <= ASO_TIME_RST;
    else if (!awake_s)
      time_ff <= ASO_TIME_RST; // RULE19
    else
      time_ff <= time_ff + 10'h001; // RULE2
  end

  assign in_compute = time_ff[ASO_PHASE_POS]; // RULE2
  assign period_last = (time_ff[5:0] == ASO_PERIOD_LAST);
  assign compute_next = ~time_ff[ASO_PHASE_POS] & period_last;

  // Transfer condition helpers
  assign host_busy = ~mode_s & ~cs_n_s & pend_ff; // RULE14
  assign self_start = mode_s & compute_next & ~cs_n_s & pend_ff & (rs_ff == ASO_RS_FULL)
                      & (xs_ff == ASO_XS_OFF); // RULE3
  assign self_bit_end = (xs_ff == ASO_XS_SEND) & (phase_ff == ASO_PHASE_END);
  assign last_bit = (bit_cnt_ff == ASO_LAST_BIT);
  assign shift_now = (self_bit_end & in_compute) | (~mode_s & ~cs_n_s & pend_ff & host_fall
                     & (rs_ff == ASO_RS_FULL)); // RULE9 RULE12
  assign load_now = (rs_ff == ASO_RS_GAP) & (gap_ff == ASO_GAP_CLKS - 3'h1);

  // Word-ready state: load, gap before a late load, emptied after LSB
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rs_ff <= ASO_RS_EMPTY;
      gap_ff <= ASO_GAP_RST;
    end
    else if (!awake_s)
    begin
      rs_ff <= ASO_RS_EMPTY; // RULE19
      gap_ff <= ASO_GAP_RST;
    end
    else
    begin
      case (rs_ff)
        ASO_RS_EMPTY:
        begin
          if (conv_stb_in)
            rs_ff <= ASO_RS_FULL; // RULE21
        end
        ASO_RS_FULL:
        begin
          if (conv_stb_in && !host_busy && pend_ff)
          begin
            rs_ff <= ASO_RS_GAP; // RULE7 RULE17
            gap_ff <= ASO_GAP_RST;
          end
          else if (shift_now && last_bit)
            rs_ff <= ASO_RS_EMPTY; // RULE4 RULE13
        end
        ASO_RS_GAP:
        begin
          gap_ff <= gap_ff + 3'h1;
          if (load_now)
            rs_ff <= ASO_RS_FULL; // RULE7 RULE17
        end
        default:
          rs_ff <= ASO_RS_EMPTY;
      endcase
    end
  end

  // Held word, shift register and bit counter
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      shreg_ff <= ASO_WORD_RST;
      next_word_ff <= ASO_WORD_RST;
      bit_cnt_ff <= ASO_BIT_CNT_RST;
      pend_ff <= 1'b0;
    end
    else if (!awake_s)
      pend_ff <= 1'b0; // RULE19
    else if (conv_stb_in && rs_ff != ASO_RS_GAP && !host_busy)
    begin
      if (pend_ff && rs_ff == ASO_RS_FULL)
        next_word_ff <= conv_word_in; // RULE7 RULE17
      else
      begin
        shreg_ff <= conv_word_in; // RULE21
        bit_cnt_ff <= ASO_BIT_CNT_RST;
        pend_ff <= 1'b1;
      end
    end
    else if (load_now)
    begin
      shreg_ff <= next_word_ff; // RULE21
      bit_cnt_ff <= ASO_BIT_CNT_RST;
      pend_ff <= 1'b1;
    end
    else if (shift_now)
    begin
      shreg_ff <= {shreg_ff[ASO_WORD_W-2:0], 1'b0}; // RULE3 RULE12
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (last_bit)
        pend_ff <= 1'b0; // RULE4 RULE13
    end
  end

  // Self-clocked transfer state and bit phase
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      xs_ff <= ASO_XS_OFF;
      phase_ff <= ASO_PHASE_RST;
    end
    else if (!awake_s || rs_ff == ASO_RS_GAP)
    begin
      xs_ff <= ASO_XS_OFF; // RULE19
      phase_ff <= ASO_PHASE_RST;
    end
    else
    begin
      case (xs_ff)
        ASO_XS_OFF:
        begin
          phase_ff <= ASO_PHASE_RST;
          if (self_start)
            xs_ff <= ASO_XS_SEND; // RULE1 RULE3 RULE6
        end
        ASO_XS_SEND:
        begin
          phase_ff <= phase_ff + 2'h1;
          if (self_bit_end && (last_bit || cs_n_s || period_last))
            xs_ff <= ASO_XS_OFF; // RULE5 RULE9
        end
        default:
          xs_ff <= ASO_XS_OFF;
      endcase
    end
  end

  // Serial clock pin: driven only in self-clocked mode while sending
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sclk_o_ff <= 1'b1;
      sclk_oe_ff <= 1'b0;
    end
    else if (!awake_s)
    begin
      sclk_o_ff <= 1'b1;
      sclk_oe_ff <= 1'b0; // RULE19
    end
    else if (self_start || (self_bit_end && !(last_bit || cs_n_s || period_last)))
    begin
      sclk_o_ff <= 1'b0; // RULE8
      sclk_oe_ff <= 1'b1; // RULE1
    end
    else if (xs_ff == ASO_XS_SEND && phase_ff == ASO_PHASE_RISE)
      sclk_o_ff <= 1'b1; // RULE8
    else if (xs_ff != ASO_XS_SEND || self_bit_end)
    begin
      sclk_o_ff <= 1'b1;
      sclk_oe_ff <= 1'b0; // RULE5 RULE9
    end
  end

  // Data pin: self-clocked changes with falling clock, host mode follows chip select
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      serial_out_line_o_ff <= 1'b1;
      serial_out_line_oe_ff <= 1'b0;
    end
    else if (!awake_s)
      serial_out_line_oe_ff <= 1'b0; // RULE19
    else if (mode_s)
    begin
      if (self_start)
      begin
        serial_out_line_o_ff <= shreg_ff[ASO_WORD_W-1]; // RULE3 RULE8
        serial_out_line_oe_ff <= 1'b1;
      end
      else if (self_bit_end && !(last_bit || cs_n_s || period_last))
        serial_out_line_o_ff <= shreg_ff[ASO_WORD_W-2]; // RULE8
      else if (self_bit_end || xs_ff != ASO_XS_SEND)
        serial_out_line_oe_ff <= 1'b0; // RULE5 RULE9
    end
    else
    begin
      serial_out_line_o_ff <= shreg_ff[ASO_WORD_W-1]; // RULE11 RULE16
      serial_out_line_oe_ff <= ~cs_n_s & pend_ff & (rs_ff == ASO_RS_FULL); // RULE10 RULE13 RULE15
    end
  end

  // Word-ready pin: floated in host mode once the word is out
  always_ff @(posedge link.master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rdy_o_ff <= 1'b1;
      rdy_oe_ff <= 1'b0;
      asleep_ff <= 1'b0;
    end
    else
    begin
      asleep_ff <= ~awake_s;
      rdy_o_ff <= (rs_ff != ASO_RS_FULL); // RULE4 RULE7
      rdy_oe_ff <= awake_s & (mode_s | (rs_ff != ASO_RS_EMPTY)); // RULE13 RULE19
    end
  end

  // Pin and user-side outputs, all from flip-flops
  assign link.serial_clk_dev_o = sclk_o_ff;
  assign link.serial_clk_dev_oe = sclk_oe_ff;
  assign link.serial_out_o = serial_out_line_o_ff;
  assign link.serial_out_oe = serial_out_line_oe_ff;
  assign link.word_ready_o = rdy_o_ff;
  assign link.word_ready_oe = rdy_oe_ff;
  assign word_pending_out = pend_ff;
  assign asleep_out = asleep_ff;

endmodule : aso_dev_port

// File: rtl/aso_host_port.sv
/*
  Host end: drives mode, sleep and chip select, and reads one 20-bit
  word per request, on the device's clock or on its own.
  Assumes core_clk_in runs well above the master clock; link inputs
  are synchronised here.
*/
`timescale 1ns/100ps
module aso_host_port
  import aso_pkg::*;
(
  aso_link_if.host link,
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic mode_sel_in,
  input wire logic sleep_req_in,
  input wire logic read_req_in,
  output logic [ASO_WORD_W-1:0] word_out,
  output logic word_valid_out,
  output logic busy_out
);

  logic [2:0] in_s1_ff;
  logic [2:0] in_s2_ff;
  logic clk_prev_ff;
  logic clk_rise;
  aso_host_t hs_ff;
  logic [4:0] half_ff;
  logic [ASO_BIT_CNT_W-1:0] cnt_ff;
  logic [ASO_WORD_W-1:0] shift_ff;
  logic [ASO_WORD_W-1:0] word_ff;
  logic valid_ff;
  logic cs_n_ff;
  logic sclk_ff;
  logic mode_ff;
  logic sleep_n_ff;
  logic host_clk_oe_ff;
  logic busy_ff;

  // Synchronise serial clock, data and ready into the core domain
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      in_s1_ff <= 3'h7;
      in_s2_ff <= 3'h7;
      clk_prev_ff <= 1'b1;
    end
    else
    begin
      in_s1_ff <= {link.word_ready_n, link.serial_out_line, link.serial_clk_line};
      in_s2_ff <= in_s1_ff;
      clk_prev_ff <= in_s2_ff[0];
    end
  end

  assign clk_rise = ~clk_prev_ff & in_s2_ff[0]; // RULE8

  // Mode and sleep pins follow the user inputs
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mode_ff <= 1'b0;
      sleep_n_ff <= 1'b1;
      host_clk_oe_ff <= 1'b1;
    end
    else
    begin
      mode_ff <= mode_sel_in;
      sleep_n_ff <= ~sleep_req_in;
      host_clk_oe_ff <= ~mode_sel_in; // RULE12
    end
  end

  // Read sequencer for both modes
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hs_ff <= ASO_HS_IDLE;
      half_ff <= ASO_HALF_RST;
      cnt_ff <= ASO_BIT_CNT_RST;
      shift_ff <= ASO_WORD_RST;
      word_ff <= ASO_WORD_RST;
      valid_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      busy_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= 1'b0;
      case (hs_ff)
        ASO_HS_IDLE:
        begin
          cnt_ff <= ASO_BIT_CNT_RST;
          busy_ff <= read_req_in; // Busy from the edge the request is taken
          if (read_req_in && mode_ff)
          begin
            cs_n_ff <= 1'b0;
            hs_ff <= ASO_HS_COLLECT;
          end
          else if (read_req_in)
            hs_ff <= ASO_HS_WAIT_RDY;
        end
        ASO_HS_COLLECT:
        begin
          if (clk_rise)
          begin
            shift_ff <= {shift_ff[ASO_WORD_W-2:0], in_s2_ff[1]}; // RULE8
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == ASO_LAST_BIT)
            begin
              word_ff <= {shift_ff[ASO_WORD_W-2:0], in_s2_ff[1]};
              busy_ff <= 1'b0;
              valid_ff <= 1'b1;
              cs_n_ff <= 1'b1;
              hs_ff <= ASO_HS_IDLE;
            end
          end
        end
        ASO_HS_WAIT_RDY:
        begin
          if (!in_s2_ff[2])
          begin
            cs_n_ff <= 1'b0;
            half_ff <= ASO_HALF_LOAD;
            hs_ff <= ASO_HS_HIGH;
          end
        end
        ASO_HS_HIGH:
        begin
          half_ff <= half_ff - 5'h01;
          if (half_ff == ASO_HALF_RST)
          begin
            shift_ff <= {shift_ff[ASO_WORD_W-2:0], in_s2_ff[1]};
            cnt_ff <= cnt_ff + 5'h01;
            sclk_ff <= 1'b0; // RULE12
            half_ff <= ASO_HALF_LOAD;
            hs_ff <= ASO_HS_LOW;
          end
        end
        ASO_HS_LOW:
        begin
          half_ff <= half_ff - 5'h01;
          if (half_ff == ASO_HALF_RST)
          begin
            sclk_ff <= 1'b1;
            half_ff <= ASO_HALF_LOAD;
            if (cnt_ff == ASO_HOST_BITS)
            begin
              word_ff <= shift_ff;
              busy_ff <= 1'b0;
              valid_ff <= 1'b1;
              cs_n_ff <= 1'b1;
              hs_ff <= ASO_HS_IDLE;
            end
            else
              hs_ff <= ASO_HS_HIGH;
          end
        end
        default:
          hs_ff <= ASO_HS_IDLE;
      endcase
    end
  end

  // Outputs; host drives the serial clock only in host-clocked mode
  assign link.chip_sel_n = cs_n_ff;
  assign link.mode_pin = mode_ff;
  assign link.sleep_n = sleep_n_ff;
  assign link.serial_clk_host_o = sclk_ff;
  assign link.serial_clk_host_oe = host_clk_oe_ff; // RULE12
  assign word_out = word_ff;
  assign word_valid_out = valid_ff;
  assign busy_out = busy_ff;

endmodule : aso_host_port

// File: test/aso_link_assertions.sv
/*
  Concurrent checks on the link pins between the device and host ends.
  Assumes master_clock_in clocks all checks; sys_rst_in is async high.
*/
`timescale 1ns/100ps
module aso_link_assertions
(
  input wire logic master_clock_in,
  input wire logic sys_rst_in,
  input wire logic chip_sel_n,
  input wire logic mode_pin,
  input wire logic sleep_n,
  input wire logic serial_clk_dev_o,
  input wire logic serial_clk_dev_oe,
  input wire logic serial_clk_host_oe,
  input wire logic serial_clk_line,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic word_ready_o,
  input wire logic word_ready_oe
);
  default clocking cb @(posedge master_clock_in);
  endclocking
  default disable iff (sys_rst_in);
  logic [6:0] burst_cnt_ff;
  logic [2:0] hi_cnt_ff;

  // Run lengths of device clock drive and of driven ready high
  always_ff @(posedge master_clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      burst_cnt_ff <= 7'h00;
      hi_cnt_ff <= 3'h0;
    end
    else
    begin
      burst_cnt_ff <= serial_clk_dev_oe ? burst_cnt_ff + 7'h01 : 7'h00;
      hi_cnt_ff <= !(word_ready_oe && word_ready_o) ? 3'h0 :
                   hi_cnt_ff + ((hi_cnt_ff != 3'h7) ? 3'h1 : 3'h0);
    end
  end

  // High half of a self-clocked bit cell, then fall or float
  sequence s_cell_high;
    serial_clk_dev_o [*2] ##1 (!serial_clk_dev_o || !serial_clk_dev_oe);
  endsequence
  // Chip select held high in host-clocked mode
  sequence s_cs_idle_host;
    (!mode_pin && chip_sel_n) [*5];
  endsequence

  chk_host_clk_off: assert property (!(serial_clk_host_oe && serial_clk_dev_oe))
    else $error("both ends drive the serial clock");
  chk_dev_clk_off: assert property ((!mode_pin) [*4] |-> !serial_clk_dev_oe)
    else $error("device drives serial clock in host mode");
  chk_self_cell: assert property ($rose(serial_clk_dev_o) && serial_clk_dev_oe &&
    $past(serial_clk_dev_oe) |-> s_cell_high) else $error("bit cell high time wrong");
  chk_self_data_fall: assert property (serial_clk_dev_oe && $past(serial_clk_dev_oe) &&
    $changed(serial_out_o) |-> $fell(serial_clk_dev_o)) else $error("data moved off falling edge");
  chk_self_burst_len: assert property (serial_clk_dev_oe |-> burst_cnt_ff < 7'h40)
    else $error("self clock runs past one period");
  chk_self_cs_stop: assert property (chip_sel_n [*8] |-> !serial_clk_dev_oe)
    else $error("self clock still driven after deselect");
  chk_host_cs_float: assert property (s_cs_idle_host |-> !serial_out_oe)
    else $error("data driven while deselected");
  chk_host_cs_drive: assert property ($fell(chip_sel_n) && !mode_pin && word_ready_oe &&
    !word_ready_o |-> ##[1:6] serial_out_oe) else $error("data not driven after select");
  chk_host_data_edge: assert property (!mode_pin && serial_out_oe && $past(serial_out_oe) &&
    $changed(serial_out_o) |-> !serial_clk_line) else $error("data moved with host clock high");
  chk_ready_gap_len: assert property (word_ready_oe && !word_ready_o &&
    $past(word_ready_oe) && $past(word_ready_o) |-> hi_cnt_ff >= 3'h4)
    else $error("ready gap shorter than four clocks");
  chk_sleep_float: assert property ((!sleep_n) [*4] |-> !serial_out_oe &&
    !serial_clk_dev_oe && !word_ready_oe) else $error("pins driven in sleep");
endmodule : aso_link_assertions

// File: test/tb_adc_serial_output_port.sv
/*
  Bench joining device and host ends: host and self clocked reads, late
  and dropped words, sleep. Assumes package and link compiled first.
*/
`timescale 1ns/100ps
module tb_adc_serial_output_port import aso_pkg::*;;
  localparam int WAIT_MAX = 8000;
  localparam int CYC_CEIL = 60000;
  logic core_clk_in, master_clock_in, sys_rst_in, mode_sel_in, sleep_req_in;
  logic read_req_in, conv_stb_in, word_valid_out, busy_out, word_pending_out, asleep_out;
  logic [ASO_WORD_W-1:0] conv_word_in, word_out, wd, wd2;
  logic [ASO_WORD_W-1:0] exp_q[$];
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  // Core clock and unrelated link clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    master_clock_in = 1'b0;
    #1.7;
    forever #6 master_clock_in = ~master_clock_in;
  end

  // Both ends facing each other across the link
  aso_link_if link_if (.master_clock_in(master_clock_in));
  aso_dev_port i_aso_dev_port (.link(link_if.dev), .sys_rst_in(sys_rst_in),
    .conv_word_in(conv_word_in), .conv_stb_in(conv_stb_in),
    .word_pending_out(word_pending_out), .asleep_out(asleep_out));
  aso_host_port i_aso_host_port (.link(link_if.host), .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .mode_sel_in(mode_sel_in), .sleep_req_in(sleep_req_in),
    .read_req_in(read_req_in), .word_out(word_out), .word_valid_out(word_valid_out),
    .busy_out(busy_out));
  aso_link_assertions i_aso_link_assertions (.master_clock_in(master_clock_in),
    .sys_rst_in(sys_rst_in), .chip_sel_n(link_if.chip_sel_n), .mode_pin(link_if.mode_pin),
    .sleep_n(link_if.sleep_n), .serial_clk_dev_o(link_if.serial_clk_dev_o),
    .serial_clk_dev_oe(link_if.serial_clk_dev_oe),
    .serial_clk_host_oe(link_if.serial_clk_host_oe),
    .serial_clk_line(link_if.serial_clk_line), .serial_out_o(link_if.serial_out_o),
    .serial_out_oe(link_if.serial_out_oe), .word_ready_o(link_if.word_ready_o),
    .word_ready_oe(link_if.word_ready_oe));

  task check_word(input logic [ASO_WORD_W-1:0] got, input logic [ASO_WORD_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task mwait(input int n);
    repeat (n) @(posedge master_clock_in);
  endtask : mwait

  // One-cycle conversion strobe on the link clock
  task load_word(input logic [ASO_WORD_W-1:0] w);
    @(posedge master_clock_in);
    conv_word_in <= w;
    conv_stb_in <= 1'b1;
    @(posedge master_clock_in);
    conv_stb_in <= 1'b0;
  endtask : load_word

  // Request one read and wait, bounded, for the word
  task automatic read_word();
    int k;
    k = 0;
    @(posedge core_clk_in);
    read_req_in <= 1'b1;
    @(posedge core_clk_in);
    read_req_in <= 1'b0;
    while (word_valid_out !== 1'b1 && k < WAIT_MAX)
    begin
      @(posedge core_clk_in);
      k++;
    end
    if (k == WAIT_MAX)
      err_count++;
    repeat (4) @(posedge core_clk_in);
  endtask : read_word

  task do_reset(input logic m);
    @(posedge core_clk_in);
    mode_sel_in <= m;
    sys_rst_in <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    mwait(8);
  endtask : do_reset

  task conclude();
    if (exp_q.size() != 0)
      err_count++; // Notes never matched by a word count as one miss in all
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // Scoreboard: each received word against the oldest note
  always @(posedge core_clk_in)
    if (word_valid_out === 1'b1)
      check_word(word_out, (exp_q.size() == 0) ? ~word_out : exp_q.pop_front());

  // Hang guard
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == CYC_CEIL)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    sys_rst_in = 1'b1;
    mode_sel_in = 1'b0;
    sleep_req_in = 1'b0;
    read_req_in = 1'b0;
    conv_stb_in = 1'b0;
    conv_word_in = 20'h00000;
    void'($urandom(32'h3795F823));
    do_reset(1'b0);
    // Host-clocked reads of edge and random words; lines float after
    for (int i = 0; i < 4; i++)
    begin
      wd = (i == 0) ? 20'hFFFFF : (i == 1) ? 20'h00001 : ASO_WORD_W'($urandom);
      load_word(wd);
      exp_q.push_back(wd);
      read_word();
      mwait(6);
      check_bit(link_if.word_ready_oe, 1'b0);
      check_bit(link_if.serial_out_oe, 1'b0);
      check_bit(word_pending_out, 1'b0);
      check_bit(busy_out, 1'b0);
    end
    // Unsent word replaced by a later one while deselected
    wd = ASO_WORD_W'($urandom);
    wd2 = ~wd;
    load_word(wd);
    mwait(10);
    load_word(wd2);
    exp_q.push_back(wd2);
    mwait(8);
    read_word();
    // Word arriving during a running read is lost
    load_word(wd);
    exp_q.push_back(wd);
    fork
      read_word();
      begin
        repeat (200) @(posedge core_clk_in);
        check_bit(busy_out, 1'b1);
        load_word(wd2);
      end
    join
    mwait(6);
    check_bit(word_pending_out, 1'b0);
    // Sleep empties the held word
    load_word(wd);
    mwait(4);
    check_bit(word_pending_out, 1'b1);
    @(posedge core_clk_in) sleep_req_in <= 1'b1;
    mwait(8);
    check_bit(asleep_out, 1'b1);
    check_bit(word_pending_out, 1'b0);
    @(posedge core_clk_in) sleep_req_in <= 1'b0;
    mwait(8);
    check_bit(asleep_out, 1'b0);
    // Self-clocked reads, then a late word replacing an unsent one after the ready gap
    do_reset(1'b1);
    wd = ASO_WORD_W'($urandom);
    load_word(wd);
    exp_q.push_back(wd);
    read_word();
    mwait(4);
    check_bit(link_if.word_ready_n, 1'b1);
    check_bit(link_if.word_ready_oe, 1'b1);
    load_word(wd2);
    mwait(10);
    load_word(wd);
    exp_q.push_back(wd);
    mwait(8);
    read_word();
    conclude();
  end
endmodule : tb_adc_serial_output_port
